/* File: register_entry_decode.v */
/*
 * register-entry decoder: executes immediate, mask, constant, vector clear
 * and semaphore entry instructions and steers other opcodes to their units.
 * assumes the issue logic presents one parcel with its long immediate, the
 * current destination scalar value and the addressed Ak value, all on sys_clk_i.
 */
// Contract
// - route non-transmit opcodes to the functional unit chosen by opcode
// - complemented long immediate entry writes one's complement into address register
// - low merge writes immediate to scalar bits 0-31, keeps 32-63
// - high merge writes immediate to scalar bits 32-63, keeps 0-31
// - complemented scalar entry writes inverted immediate low, ones in bits 32-63
// - ones mask from right sets count low bits; short field holds 100 minus count
// - zeros mask from right clears count low bits, sets the others
// - sign-bit entry loads only bit 63 set
// - complemented sign-bit entry loads bit 63 clear, others set
// - three-quarters scale constant entry loads its fixed float pattern
// - minor field selects fixed float constants 0.5, 1.0, 2.0, 4.0
// - clear one vector element indexed by Ak, or a whole vector register
// - select bit zero: test-and-set semaphore numbered by short field
// - select bit one: test-and-set semaphore numbered by address register
// - clear opcode clears one semaphore chosen by short field or address register
// - set opcode sets one semaphore chosen by short field or address register
// - register zero as non-destination operand yields a fixed special operand
// - privileged instruction outside monitor mode executes as no-operation
`timescale 1ns/1ps
`include "register_entry_map.vh"

module register_entry_decode #(
  parameter ADDR_W = 32,
  parameter SEM_COUNT = 32
) (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // issue side
  input wire issue_valid_i,
  input wire [15:0] parcel_i,
  input wire [31:0] long_immediate_field_i,
  input wire privileged_i,
  input wire monitor_mode_i,
  input wire [63:0] scalar_dest_value_i,
  input wire [ADDR_W-1:0] addr_reg_index_i,
  output wire issue_accept_o,
  output wire ts_wait_o,
  // address register write
  output reg a_write_o,
  output reg [2:0] addr_reg_dest_o,
  output reg [ADDR_W-1:0] a_data_o,
  // scalar register write
  output reg s_write_o,
  output reg [2:0] s_dest_o,
  output reg [63:0] s_data_o,
  // vector register clears
  output reg v_elem_clear_o,
  output reg v_all_clear_o,
  output reg [2:0] vector_reg_dest_o,
  output reg [ADDR_W-1:0] v_elem_index_o,
  // functional unit steering
  output reg [`FU_COUNT-1:0] fu_select_o,
  // shared semaphores
  output reg [SEM_COUNT-1:0] semaphore_bank
);

  // parcel fields
  wire [6:0] opcode = parcel_i[`OPC_HI:`OPC_LO];
  wire [2:0] fld_i = parcel_i[`FLD_I_HI:`FLD_I_LO];
  wire [2:0] fld_j = parcel_i[`FLD_J_HI:`FLD_J_LO];
  wire [2:0] fld_k = parcel_i[`FLD_K_HI:`FLD_K_LO];
  wire [5:0] short_immediate_field = parcel_i[`FLD_J_HI:`FLD_K_LO];
  wire semaphore_select_bit = short_immediate_field[`SEM_SEL_BIT];

  // functional unit choice from opcode and minor fields
  function [`FU_COUNT-1:0] fu_decode;
    input [6:0] op;
    input [2:0] k;
    begin
      fu_decode = {`FU_COUNT{1'b0}};
      if (op == 7'h18 || op == 7'h19) begin
        fu_decode[`FU_ADDR_ADD] = 1'b1;
      end
      if (op == 7'h1A) begin
        fu_decode[`FU_ADDR_MUL] = 1'b1;
      end
      if (op == 7'h30 || op == 7'h31) begin
        fu_decode[`FU_S_ADD] = 1'b1;
      end
      if (op >= 7'h22 && op <= 7'h29) begin
        fu_decode[`FU_S_LOGIC] = 1'b1;
      end
      if (op >= 7'h2A && op <= 7'h2F) begin
        fu_decode[`FU_S_SHIFT] = 1'b1;
      end
      if (op == 7'h16 || op == 7'h17) begin
        fu_decode[`FU_S_POP] = 1'b1;
      end
      if (op >= 7'h6C && op <= 7'h6F) begin
        fu_decode[`FU_V_ADD] = 1'b1;
      end
      if ((op >= 7'h60 && op <= 7'h67) || op == 7'h7D) begin
        fu_decode[`FU_V_LOGIC] = 1'b1;
      end
      if (op >= 7'h60 && op <= 7'h65) begin
        fu_decode[`FU_V_LOGIC2] = 1'b1;
      end
      if (op >= 7'h68 && op <= 7'h6B) begin
        fu_decode[`FU_V_SHIFT] = 1'b1;
      end
      if (op == 7'h7C && (k == 3'h1 || k == 3'h2)) begin
        fu_decode[`FU_V_POP] = 1'b1;
      end
      if (op == 7'h32 || op == 7'h33 || (op >= 7'h78 && op <= 7'h7B)) begin
        fu_decode[`FU_F_ADD] = 1'b1;
      end
      if ((op >= 7'h34 && op <= 7'h37) || (op >= 7'h70 && op <= 7'h77)) begin
        fu_decode[`FU_F_MUL] = 1'b1;
      end
      if (op == 7'h38 || (op == 7'h7C && k == 3'h0)) begin
        fu_decode[`FU_F_RECIP] = 1'b1;
      end
      if (op >= 7'h40 && op <= 7'h5F) begin
        fu_decode[`FU_MEM_S] = 1'b1;
      end
      if (op == 7'h7E || op == 7'h7F) begin
        fu_decode[`FU_MEM_V] = 1'b1;
      end
    end
  endfunction

  // Ak operand with the register-zero substitution
  function [ADDR_W-1:0] ak_operand;
    input [2:0] k;
    input [ADDR_W-1:0] value;
    begin
      if (k == 3'h0) begin
        ak_operand = `AK_ZERO_VALUE;
      end else begin
        ak_operand = value;
      end
    end
  endfunction

  // right-justified mask count: octal 100 minus the short field
  wire [6:0] mask_count = `MASK_BASE - {1'b0, short_immediate_field};
  wire [63:0] low_ones;

  mask_former #(
    .WORD_W(64)
  ) u_mask (
    .count_i(mask_count),
    .mask_o(low_ones)
  );

  // semaphore addressing and state of the addressed bit
  wire [ADDR_W-1:0] ak_value = ak_operand(fld_k, addr_reg_index_i);
  wire [4:0] sem_num = semaphore_select_bit ? ak_value[4:0]
                                            : short_immediate_field[4:0];
  wire sem_in_range = semaphore_select_bit ? (ak_value < SEM_COUNT) : (short_immediate_field[4:0] < SEM_COUNT);
  wire sem_current = sem_in_range ? semaphore_bank[sem_num] : 1'b0;

  // a privileged parcel outside monitor mode has no effect at all
  wire executes = issue_valid_i && !(privileged_i && !monitor_mode_i);
  wire is_sem = opcode == `OP_SEMAPHORE;
  wire is_ts = executes && is_sem && fld_i == `SEM_TEST_SET;

  // test-and-set on a set semaphore holds issue until another party clears it
  assign ts_wait_o = is_ts && sem_current;
  assign issue_accept_o = issue_valid_i && !ts_wait_o;
  wire fire = executes && !ts_wait_o;

  // next values of the write ports
  reg next_a_write;
  reg [ADDR_W-1:0] next_a_data;
  reg next_s_write;
  reg [63:0] next_s_data;
  reg next_v_elem;
  reg next_v_all;

  // entry decode
  always @* begin
    next_a_write = 1'b0;
    next_a_data = {ADDR_W{1'b0}};
    next_s_write = 1'b0;
    next_s_data = 64'h0000000000000000;
    next_v_elem = 1'b0;
    next_v_all = 1'b0;
    if (fire) begin
      case (opcode)
        `OP_A_LONG: begin
          next_a_write = (fld_j == 3'h0) && (fld_k == 3'h0);
          next_a_data = long_immediate_field_i[ADDR_W-1:0];
        end
        `OP_A_LONG_NOT: begin
          next_a_write = (fld_j == 3'h0) && (fld_k == 3'h0);
          next_a_data = ~long_immediate_field_i[ADDR_W-1:0];
        end
        `OP_A_SHORT: begin
          next_a_write = 1'b1;
          next_a_data = {{(ADDR_W-6){1'b0}}, short_immediate_field};
        end
        `OP_A_NEG: begin
          // negative of the Ak special operand 1 is all ones
          next_a_write = (fld_j == 3'h0) && (fld_k == 3'h0);
          next_a_data = {ADDR_W{1'b0}} - ak_operand(fld_k, addr_reg_index_i);
        end
        `OP_S_LONG: begin
          next_s_write = (fld_k == 3'h0) && (fld_j == `S_LONG_PLAIN || fld_j == `S_LONG_LOW ||
                                            fld_j == `S_LONG_HIGH);
          case (fld_j)
            `S_LONG_LOW: next_s_data = {scalar_dest_value_i[63:32], long_immediate_field_i};
            `S_LONG_HIGH: next_s_data = {long_immediate_field_i, scalar_dest_value_i[31:0]};
            default: next_s_data = {32'h00000000, long_immediate_field_i};
          endcase
        end
        `OP_S_LONG_NOT: begin
          next_s_write = (fld_j == 3'h0) && (fld_k == 3'h0);
          next_s_data = {32'hFFFFFFFF, ~long_immediate_field_i};
        end
        `OP_S_MASK_ONES: begin
          // same bits as a left zeros mask of the short field count
          next_s_write = 1'b1;
          next_s_data = low_ones;
        end
        `OP_S_MASK_ZEROS: begin
          // same bits as a left ones mask of the short field count
          next_s_write = 1'b1;
          next_s_data = ~low_ones;
        end
        `OP_S_NOT_SK: begin
          // Sk with k zero stands for the sign bit
          next_s_write = (fld_j == 3'h0) && (fld_k == 3'h0);
          next_s_data = ~`K_SIGN_BIT;
        end
        `OP_S_SK: begin
          next_s_write = (fld_j == 3'h0) && (fld_k == 3'h0);
          next_s_data = `K_SIGN_BIT;
        end
        `OP_S_CONST: begin
          // j values below three are register transfers, not entries
          next_s_write = (fld_k == 3'h0) && (fld_j >= 3'h3);
          case (fld_j)
            3'h3: next_s_data = `K_THREE_QTR;
            3'h4: next_s_data = `K_POINT_FOUR;
            3'h5: next_s_data = `K_ONE;
            3'h6: next_s_data = `K_TWO;
            3'h7: next_s_data = `K_FOUR;
            default: next_s_data = 64'h0000000000000000;
          endcase
        end
        `OP_V_ELEM: begin
          next_v_elem = (fld_j == 3'h0);
        end
        `OP_V_CLEAR: begin
          next_v_all = (fld_j == fld_i) && (fld_k == fld_i);
        end
        default: begin
          next_a_write = 1'b0;
        end
      endcase
    end
  end

  // registered write ports and unit steering
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      a_write_o <= 1'b0;
      addr_reg_dest_o <= 3'h0;
      a_data_o <= {ADDR_W{1'b0}};
      s_write_o <= 1'b0;
      s_dest_o <= 3'h0;
      s_data_o <= 64'h0000000000000000;
      v_elem_clear_o <= 1'b0;
      v_all_clear_o <= 1'b0;
      vector_reg_dest_o <= 3'h0;
      v_elem_index_o <= {ADDR_W{1'b0}};
      fu_select_o <= {`FU_COUNT{1'b0}};
    end else begin
      a_write_o <= next_a_write;
      addr_reg_dest_o <= fld_i;
      a_data_o <= next_a_data;
      s_write_o <= next_s_write;
      s_dest_o <= fld_i;
      s_data_o <= next_s_data;
      v_elem_clear_o <= next_v_elem;
      v_all_clear_o <= next_v_all;
      vector_reg_dest_o <= fld_i;
      v_elem_index_o <= ak_value;
      fu_select_o <= fire ? fu_decode(opcode, fld_k) : {`FU_COUNT{1'b0}};
    end
  end

  // semaphore bank updates
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      semaphore_bank <= {SEM_COUNT{1'b0}};
    end else if (fire && is_sem && sem_in_range) begin
      case (fld_i)
        `SEM_TEST_SET: semaphore_bank[sem_num] <= 1'b1;
        `SEM_CLEAR: semaphore_bank[sem_num] <= 1'b0;
        `SEM_SET: semaphore_bank[sem_num] <= 1'b1;
        default: semaphore_bank[sem_num] <= semaphore_bank[sem_num];
      endcase
    end
  end

endmodule

/* File: register_entry_map.vh */
/*
 * constants for the register-entry decoder: opcode values, field positions,
 * fixed operand patterns and functional unit select indices.
 * assumes a 16-bit instruction parcel laid out as a 7-bit opcode followed by
 * three 3-bit designators i, j and k.
 */
`ifndef REGISTER_ENTRY_MAP_VH
`define REGISTER_ENTRY_MAP_VH

// parcel field positions
`define OPC_HI 15
`define OPC_LO 9
`define FLD_I_HI 8
`define FLD_I_LO 6
`define FLD_J_HI 5
`define FLD_J_LO 3
`define FLD_K_HI 2
`define FLD_K_LO 0
// semaphore select bit inside the short immediate field
`define SEM_SEL_BIT 5

// opcodes, written as their hexadecimal values
`define OP_SEMAPHORE 7'h03
`define OP_A_LONG 7'h10
`define OP_A_LONG_NOT 7'h11
`define OP_A_SHORT 7'h12
`define OP_A_NEG 7'h19
`define OP_S_LONG 7'h20
`define OP_S_LONG_NOT 7'h21
`define OP_S_MASK_ONES 7'h22
`define OP_S_MASK_ZEROS 7'h23
`define OP_S_NOT_SK 7'h27
`define OP_S_SK 7'h29
`define OP_S_CONST 7'h39
`define OP_V_ELEM 7'h3F
`define OP_V_CLEAR 7'h65

// i designator values of the semaphore group
`define SEM_TEST_SET 3'h4
`define SEM_CLEAR 3'h6
`define SEM_SET 3'h7

// j designator values of the long scalar entries
`define S_LONG_PLAIN 3'h0
`define S_LONG_LOW 3'h2
`define S_LONG_HIGH 3'h4

// mask forms count from octal 100
`define MASK_BASE 7'h40

// fixed scalar patterns
`define K_SIGN_BIT 64'h8000000000000000
`define K_THREE_QTR 64'h4030C00000000000
`define K_POINT_FOUR 64'h4000800000000000
`define K_ONE 64'h4001800000000000
`define K_TWO 64'h4002800000000000
`define K_FOUR 64'h4003800000000000

// special operand substituted for address register zero in the k field
`define AK_ZERO_VALUE 32'h00000001

// functional unit select indices
`define FU_ADDR_ADD 0
`define FU_ADDR_MUL 1
`define FU_S_ADD 2
`define FU_S_LOGIC 3
`define FU_S_SHIFT 4
`define FU_S_POP 5
`define FU_V_ADD 6
`define FU_V_LOGIC 7
`define FU_V_LOGIC2 8
`define FU_V_SHIFT 9
`define FU_V_POP 10
`define FU_F_ADD 11
`define FU_F_MUL 12
`define FU_F_RECIP 13
`define FU_MEM_S 14
`define FU_MEM_V 15
`define FU_COUNT 16

`endif

/* File: mask_former.v */
/*
 * forms a word whose low count bits are one and the rest zero.
 * assumes count never exceeds the word width; a count equal to it gives all ones.
 */
`timescale 1ns/1ps
`include "register_entry_map.vh"

module mask_former #(
  parameter WORD_W = 64
) (
  // requested number of low ones
  input wire [6:0] count_i,
  // resulting mask
  output reg [WORD_W-1:0] mask_o
);

  integer b;

  // each bit is one when its position lies below the count
  always @* begin
    mask_o = {WORD_W{1'b0}};
    for (b = 0; b < WORD_W; b = b + 1) begin
      if (b < count_i) begin
        mask_o[b] = 1'b1;
      end
    end
  end

endmodule

/* File: entry_chk.sv */
/*
 * checker for the register-entry decoder: timing and value relations at its ports.
 * assumes it is bound to the decoder and sees its ports only.
 */
`timescale 1ns/1ps
module entry_chk #(
  parameter ADDR_W = 32,
  parameter SEM_COUNT = 32
) (
  // clock and reset
  input wire sys_clk_i,
  input wire reset_i,
  // issue side
  input wire issue_valid_i,
  input wire [15:0] parcel_i,
  input wire [31:0] long_immediate_field_i,
  input wire privileged_i,
  input wire monitor_mode_i,
  input wire [63:0] scalar_dest_value_i,
  input wire issue_accept_o,
  input wire ts_wait_o,
  // results
  input wire a_write_o,
  input wire [ADDR_W-1:0] a_data_o,
  input wire s_write_o,
  input wire [63:0] s_data_o,
  input wire [15:0] fu_select_o,
  input wire [SEM_COUNT-1:0] semaphore_bank
);
  reg [31:0] nm_q;
  reg [63:0] sdv_q;
  reg [4:0] sem_q;
  wire take = issue_valid_i && issue_accept_o && !(privileged_i && !monitor_mode_i);
  wire [6:0] op = parcel_i[15:9];
  wire [5:0] jk = parcel_i[5:0];
  wire sem_ts = op == 7'h03 && parcel_i[8:6] == 3'h4 && !parcel_i[5];

  // operands of the previous cycle for result comparison
  always @(posedge sys_clk_i) begin
    nm_q <= long_immediate_field_i;
    sdv_q <= scalar_dest_value_i;
    sem_q <= parcel_i[4:0];
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_addr_not:
    assert property (take && op == 7'h11 && jk == 6'h00 |=> a_write_o && a_data_o == ~nm_q) else $error("addr complement");
  a_addr_ones:
    assert property (take && op == 7'h19 && jk == 6'h00 |=> a_write_o && (&a_data_o)) else $error("addr ones");
  a_merge_low:
    assert property (take && op == 7'h20 && jk == 6'h10 |=> s_write_o && s_data_o == {sdv_q[63:32], nm_q})
      else $error("low merge");
  a_merge_high:
    assert property (take && op == 7'h20 && jk == 6'h20 |=> s_data_o == {nm_q, sdv_q[31:0]}) else $error("high merge");
  a_scalar_not:
    assert property (take && op == 7'h21 && jk == 6'h00 |=> s_data_o == {32'hFFFFFFFF, ~nm_q}) else $error("s complement");
  a_sign_bit:
    assert property (take && op == 7'h29 && jk == 6'h00 |=> s_write_o && s_data_o == 64'h8000000000000000)
      else $error("sign bit");
  a_sign_not:
    assert property (take && op == 7'h27 && jk == 6'h00 |=> s_data_o == 64'h7FFFFFFFFFFFFFFF) else $error("sign not");
  a_priv_nop:
    assert property (issue_valid_i && privileged_i && !monitor_mode_i |=> !a_write_o && !s_write_o && $stable(semaphore_bank))
      else $error("privileged not ignored");
  a_ts_sets:
    assert property (take && sem_ts |=> semaphore_bank[sem_q]) else $error("test-and-set missed");
  a_ts_waits:
    assert property (issue_valid_i && !(privileged_i && !monitor_mode_i) && sem_ts && semaphore_bank[parcel_i[4:0]]
                     |-> ts_wait_o && !issue_accept_o)
      else $error("busy semaphore taken");
  a_route_mul:
    assert property (take && op == 7'h1A |=> fu_select_o == 16'h0002) else $error("multiply route");
endmodule

bind register_entry_decode entry_chk #(.ADDR_W(ADDR_W), .SEM_COUNT(SEM_COUNT)) chk_u (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .issue_valid_i(issue_valid_i), .parcel_i(parcel_i),
  .long_immediate_field_i(long_immediate_field_i), .privileged_i(privileged_i), .monitor_mode_i(monitor_mode_i),
  .scalar_dest_value_i(scalar_dest_value_i), .issue_accept_o(issue_accept_o), .ts_wait_o(ts_wait_o),
  .a_write_o(a_write_o), .a_data_o(a_data_o), .s_write_o(s_write_o), .s_data_o(s_data_o),
  .fu_select_o(fu_select_o), .semaphore_bank(semaphore_bank)
);

/* File: issue_model.sv */
/*
 * model of the issue logic: presents one parcel with its operands and holds it until taken or its tries run out.
 * assumes accept is combinational and settles within 1 ns of a falling edge.
 */
`timescale 1ns/1ps
module issue_model (
  // clock and handshake
  input wire sys_clk_i,
  input wire issue_accept_i,
  // parcel and operands
  output reg issue_valid_o,
  output reg [15:0] parcel_o,
  output reg [31:0] nm_o,
  output reg priv_o,
  output reg monitor_o,
  output reg [63:0] sdv_o,
  output reg [31:0] ak_o
);
  // idle values at time zero
  initial begin
    issue_valid_o = 1'b0;
    parcel_o = 16'h0000;
    nm_o = 32'h00000000;
    priv_o = 1'b0;
    monitor_o = 1'b0;
    sdv_o = 64'h0;
    ak_o = 32'h00000000;
  end

  // hold the parcel across rising edges until accepted or tries run out, then scramble released lines
  task issue(input [15:0] p, input [31:0] nm, input [63:0] sv, input [31:0] ak, input integer tries,
             output reg took);
    begin
      took = 1'b0;
      @(negedge sys_clk_i);
      issue_valid_o = 1'b1;
      parcel_o = p;
      nm_o = nm;
      sdv_o = sv;
      ak_o = ak;
      repeat (tries) if (!took) begin
        #1 took = issue_accept_i;
        @(negedge sys_clk_i);
      end
      issue_valid_o = 1'b0;
      parcel_o = ~parcel_o;
      nm_o = ~nm_o;
      sdv_o = ~sdv_o;
      ak_o = ~ak_o;
    end
  endtask
endmodule

/* File: testbench.sv */
/*
 * self-checking testbench for the register-entry decoder.
 * assumes results appear at the taking edge and hold until the next edge.
 */
`timescale 1ns/1ps
module testbench;
  reg sys_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg took;
  integer bad_count = 0;
  integer compares = 0;
  integer n;
  wire valid, accept, tsw, aw, sw, vec, vall, priv, mon;
  wire [15:0] parcel, fu;
  wire [31:0] nm, ak, ad, vidx, bank;
  wire [63:0] sdv, sd;
  wire [2:0] adst, sdst, vdst;
  logic [15:0] sp [0:15] = '{16'h4040, 16'h4050, 16'h4060, 16'h4240, 16'h4478, 16'h447F, 16'h4440, 16'h4678,
                             16'h4640, 16'h5240, 16'h4E40, 16'h7258, 16'h7260, 16'h7268, 16'h7270, 16'h7278};
  logic [63:0] se [0:15] = '{64'h00000000CAFE0001, 64'h01234567CAFE0001, 64'hCAFE000189ABCDEF,
    64'hFFFFFFFF3501FFFE, 64'hFF, 64'h1, 64'hFFFFFFFFFFFFFFFF, 64'hFFFFFFFFFFFFFF00, 64'h0,
    64'h8000000000000000, 64'h7FFFFFFFFFFFFFFF, 64'h4030C00000000000, 64'h4000800000000000,
    64'h4001800000000000, 64'h4002800000000000, 64'h4003800000000000};
  logic [6:0] rop [0:13] = '{7'h18, 7'h1A, 7'h30, 7'h2A, 7'h16, 7'h6C, 7'h68, 7'h32, 7'h34, 7'h38, 7'h40, 7'h7E,
                             7'h67, 7'h60};
  logic [15:0] rfu [0:13] = '{16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0020, 16'h0040, 16'h0200, 16'h0800,
                              16'h1000, 16'h2000, 16'h4000, 16'h8000, 16'h0080, 16'h0180};

  issue_model pm (.sys_clk_i(sys_clk_i), .issue_accept_i(accept), .issue_valid_o(valid), .parcel_o(parcel),
    .nm_o(nm), .priv_o(priv), .monitor_o(mon), .sdv_o(sdv), .ak_o(ak));

  register_entry_decode dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .issue_valid_i(valid), .parcel_i(parcel),
    .long_immediate_field_i(nm), .privileged_i(priv), .monitor_mode_i(mon), .scalar_dest_value_i(sdv),
    .addr_reg_index_i(ak), .issue_accept_o(accept), .ts_wait_o(tsw), .a_write_o(aw), .addr_reg_dest_o(adst),
    .a_data_o(ad), .s_write_o(sw), .s_dest_o(sdst), .s_data_o(sd), .v_elem_clear_o(vec), .v_all_clear_o(vall),
    .vector_reg_dest_o(vdst), .v_elem_index_o(vidx), .fu_select_o(fu), .semaphore_bank(bank));

  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  // compare and count
  task chk(input [63:0] seen, input [63:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // issue one parcel that must be taken
  task go(input [15:0] p, input [31:0] v, input [31:0] a);
    begin
      pm.issue(p, v, 64'h0123456789ABCDEF, a, 4, took);
      chk(took, 1'b1);
    end
  endtask

  task t_addr;
    begin
      go(16'h2280, 32'h1234ABCD, 32'h0); chk(aw, 1'b1); chk(adst, 3'h2); chk(ad, 32'hEDCB5432);
      go(16'h3340, 32'h0, 32'h0); chk(ad, 32'hFFFFFFFF);
      go(16'h2040, 32'h89ABCDEF, 32'h0); chk(ad, 32'h89ABCDEF);
      go(16'h24EF, 32'h0, 32'h0); chk(ad, 32'h2F);
    end
  endtask

  task t_scalar;
    for (n = 0; n < 16; n = n + 1) begin
      go(sp[n] & 16'hFE3F | {7'h00, n[2:0], 6'h00}, 32'hCAFE0001, 32'h0);
      chk(sw, 1'b1); chk(sdst, n[2:0]); chk(sd, se[n]);
    end
  endtask

  task t_vec;
    begin
      go(16'h7F00, 32'h0, 32'h77); chk(vec, 1'b1); chk(vidx, 32'h1); chk(vdst, 3'h4);
      go(16'h7F03, 32'h0, 32'h2A); chk(vidx, 32'h2A); chk(vall, 1'b0);
      go(16'hCBB6, 32'h0, 32'h0); chk(vall, 1'b1); chk(vdst, 3'h6); chk(vec, 1'b0);
    end
  endtask

  task t_sem;
    begin
      go(16'h0705, 32'h0, 32'h0); chk(bank[5], 1'b1);
      fork
        pm.issue(16'h0705, 32'h0, 64'h0, 32'h0, 1, took);
        begin
          @(negedge sys_clk_i);
          #2 chk(tsw, 1'b1);
        end
      join
      chk(took, 1'b0);
      go(16'h07E1, 32'h0, 32'h9); chk(bank[9], 1'b1);
      go(16'h0721, 32'h0, 32'hC); chk(bank[12], 1'b1);
      go(16'h0720, 32'h0, 32'h1F); chk(bank[1], 1'b1);
      go(16'h0785, 32'h0, 32'h0); chk(bank[5], 1'b0);
      go(16'h07A1, 32'h0, 32'h9); chk(bank[9], 1'b0);
      go(16'h07C3, 32'h0, 32'h0); chk(bank, 32'h0000100A);
    end
  endtask

  task t_priv;
    begin
      pm.priv_o = 1'b1;
      go(16'h5240, 32'h0, 32'h0); chk(sw, 1'b0);
      go(16'h0707, 32'h0, 32'h0); chk(bank, 32'h0000100A);
      pm.monitor_o = 1'b1;
      go(16'h5240, 32'h0, 32'h0); chk(sd, 64'h8000000000000000);
      pm.priv_o = 1'b0;
      pm.monitor_o = 1'b0;
    end
  endtask

  task t_route;
    for (n = 0; n < 14; n = n + 1) begin
      go({rop[n], 9'h053}, 32'h0, 32'h5); chk(fu, rfu[n]);
    end
  endtask

  task wrap_up;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i) reset_i = 1'b0;
    t_addr;
    t_scalar;
    t_vec;
    t_sem;
    t_priv;
    t_route;
    wrap_up;
  end

  // watchdog far beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    bad_count = bad_count + 1;
    wrap_up;
  end
endmodule
